/* File: bench/mbs_host_model.sv */
// host master side: sends queued frame bytes, collects replies with stalls
module mbs_host_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxValid <= 1'b0;
      rxData <= 8'h00;
      txReady <= 1'b0;
    end else begin
      txReady <= ($urandom_range(3) != 0);
      if (txValid && txReady) rxq.push_back(txData);
      if (rxValid && rxReady) void'(txq.pop_front());
      if (txq.size() != 0) begin
        rxValid <= 1'b1;
        rxData <= txq[0];
      end else begin
        rxValid <= 1'b0;
        rxData <= ~rxData;
      end
    end
  end
endmodule : mbs_host_model

/* File: bench/mbs_rtu_slave_sva.sv */
// concurrent checks on the rtu slave ports
module mbs_rtu_slave_sva #(
  parameter int GAP_CYCLES = 20,
  parameter logic [15:0] WR_FIRST = 16'h0000,
  parameter logic [15:0] WR_LAST = 16'h00ff
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txReady,
  input wire logic regWrEn,
  input wire logic [15:0] regWrAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // idle cycles since last taken byte
  // ----------------------------------------
  int idleCnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt <= 0;
    end else if (rxValid && rxReady) begin
      idleCnt <= 0;
    end else if (idleCnt < GAP_CYCLES + 4) begin
      idleCnt <= idleCnt + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_tx_valid_hold: assert property (txValid && !txReady |=> txValid)
    else $error("tx byte withdrawn before taken");
  a_tx_data_hold: assert property (txValid && !txReady |=> $stable(txData))
    else $error("tx byte changed before taken");
  a_rx_ready_stays: assert property (rxValid && rxReady |=> rxReady)
    else $error("byte intake stopped inside frame");
  a_gap_min: assert property ($fell(rxReady) |-> idleCnt >= GAP_CYCLES - 1)
    else $error("frame closed before idle gap");
  a_gap_hold: assert property (rxReady && idleCnt < GAP_CYCLES - 1 |=> rxReady)
    else $error("intake dropped inside idle gap");
  a_wr_addr_step: assert property (regWrEn ##1 regWrEn |-> regWrAddr == $past(regWrAddr) + 16'h1)
    else $error("write addresses not ascending");
  a_wr_in_range: assert property (regWrEn |-> regWrAddr >= WR_FIRST && regWrAddr <= WR_LAST)
    else $error("write outside writable range");
  a_wr_busy: assert property (regWrEn |-> !rxReady ##1 !rxReady [*3])
    else $error("write while idle or reply skipped");
endmodule : mbs_rtu_slave_sva

bind mbs_rtu_slave mbs_rtu_slave_sva #(.GAP_CYCLES(GAP_CYCLES), .WR_FIRST(WR_FIRST),
  .WR_LAST(WR_LAST)) u_mbs_rtu_slave_sva (.clk_sys(clk_sys), .rst_n(rst_n), .rxValid(rxValid),
  .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
  .regWrEn(regWrEn), .regWrAddr(regWrAddr));

/* File: bench/tb_top.sv */
// self-checking bench of the rtu slave responder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] slaveAddr = 8'h01;
  logic rxValid, rxReady, txValid, txReady, regValueOk, regWrEn;
  logic [7:0] rxData, txData;
  logic [15:0] regRdAddr, regRdData, regChkAddr, regChkData, regWrAddr, regWrData;
  int fails = 0;
  int testsRun = 0;
  int cyc = 0;
  int nTest = 0;
  logic [7:0] req[$], exp[$];
  logic [31:0] expWr[$], gotWr[$];
  logic [7:0] fn[4] = '{8'h01, 8'h04, 8'h06, 8'h2b};
  always #25 clk_sys = ~clk_sys;
  assign regRdData = regRdAddr ^ 16'h5a5a;
  assign regValueOk = (regChkData !== 16'hffff) && (regChkData !== regChkAddr);
  always @(posedge clk_sys) if (regWrEn === 1'b1) gotWr.push_back({regWrAddr, regWrData});
  mbs_rtu_slave #(.GAP_CYCLES(GAP), .RD_LAST(16'h01ff)) u_mbs_rtu_slave (.clk_sys(clk_sys),
    .rst_n(rst_n), .slaveAddr(slaveAddr), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady), .txValid(txValid), .txData(txData), .txReady(txReady),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .regChkAddr(regChkAddr),
    .regChkData(regChkData), .regValueOk(regValueOk), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData));
  mbs_host_model u_mbs_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txReady(txReady));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc
  task automatic addCrc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask : addCrc
  task automatic model();
    logic [15:0] st, qty, v;
    logic [7:0] code;
    exp = {};
    expWr = {};
    code = 8'h00;
    st = {req[2], req[3]};
    qty = {req[4], req[5]};
    if (req[0] != slaveAddr) return;
    if (req[1] != 8'h03 && req[1] != 8'h10) code = 8'h81;
    else if (qty == 0 || qty > (req[1] == 8'h03 ? 125 : 123)) code = 8'h83;
    else if (req[1] == 8'h10 && req[6] != 8'(2 * qty)) code = 8'h83;
    else if (int'(st) + int'(qty) - 1 > (req[1] == 8'h03 ? 'h1ff : 'hff)) code = 8'h82;
    else if (req[1] == 8'h10) for (int i = 0; i < qty; i++) begin
      if ({req[7+2*i], req[8+2*i]} == 16'hffff || {req[7+2*i], req[8+2*i]} == st + 16'(i))
        code = 8'h83;
      expWr.push_back({st + 16'(i), req[7+2*i], req[8+2*i]});
    end
    if (code != 8'h00) begin
      exp = {req[0], req[1] | 8'h80, code};
      expWr = {};
    end else if (req[1] == 8'h03) begin
      exp = {req[0], 8'h03, 8'(2 * qty)};
      for (int i = 0; i < qty; i++) begin
        v = (st + 16'(i)) ^ 16'h5a5a;
        exp.push_back(v[15:8]);
        exp.push_back(v[7:0]);
      end
    end else exp = req[0:5];
    if (exp.size() != 0) addCrc(exp);
  endtask : model
  // ----------------------------------------
  // stimulus and comparison
  // ----------------------------------------
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    testsRun++;
    if (e !== a) begin
      fails++;
      $display("unexpected at %0t: expected %h got %h", $time, e, a);
    end
  endtask : check
  task automatic runReq(input logic [7:0] r[$], input bit bad);
    req = r[0:$-2];
    model();
    if (bad) exp = {};
    if (bad) expWr = {};
    u_mbs_host_model.rxq = {};
    gotWr = {};
    foreach (r[i]) u_mbs_host_model.txq.push_back(r[i]);
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk_sys);
      if (exp.size() != 0 && u_mbs_host_model.rxq.size() >= exp.size()) break;
      if (exp.size() == 0 && n > r.size() + GAP + 60) break;
    end
    check(exp.size(), u_mbs_host_model.rxq.size());
    foreach (exp[i]) if (i < u_mbs_host_model.rxq.size()) check(exp[i], u_mbs_host_model.rxq[i]);
    check(expWr.size(), gotWr.size());
    foreach (expWr[i]) if (i < gotWr.size()) check(expWr[i], gotWr[i]);
    nTest++;
    $display("test %0d done", nTest);
  endtask : runReq
  task automatic frame(input logic [7:0] a, input logic [7:0] f, input logic [15:0] st,
                       input logic [15:0] qty, input int nw, input logic [15:0] last,
                       input bit bad);
    logic [7:0] r[$];
    logic [15:0] v;
    r = {a, f, st[15:8], st[7:0], qty[15:8], qty[7:0]};
    if (f == 8'h10) r.push_back(8'(2 * nw));
    for (int i = 0; i < nw; i++) begin
      v = (i == nw - 1) ? last : 16'($urandom_range(16'hfffe));
      r.push_back(v[15:8]);
      r.push_back(v[7:0]);
    end
    addCrc(r);
    if (bad) r[r.size()-1] ^= 8'h01;
    runReq(r, bad);
  endtask : frame
  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h804b));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    runReq('{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h03, 8'h04, 8'h37}, 0);
    runReq('{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h01, 8'h04, 8'h01, 8'hf4,
             8'hb1, 8'h9d}, 0);
    check(32'h4002, {exp[6], exp[7]});
    for (int k = 0; k < 3; k++) frame(8'h01, 8'h03, 16'($urandom_range(16'h1f0)),
      16'($urandom_range(8, 1)), 0, 16'h0000, 0);
    frame(8'h01, 8'h03, 16'h0000, 16'd125, 0, 16'h0000, 0);
    frame(8'h01, 8'h03, 16'h01ff, 16'h0002, 0, 16'h0000, 0);
    frame(8'h01, 8'h10, 16'h00f0, 16'h0004, 4, 16'h1234, 0);
    frame(8'h01, 8'h10, 16'h0010, 16'h0003, 3, 16'hffff, 0);
    frame(8'h01, 8'h10, 16'h0040, 16'h0002, 2, 16'h0041, 0);
    frame(8'h01, 8'h10, 16'h0010, 16'h0002, 1, 16'h0005, 0);
    frame(8'h01, 8'h10, 16'h00ff, 16'h0002, 2, 16'h0001, 0);
    frame(8'h01, 8'h03, 16'h0000, 16'h0000, 0, 16'h0000, 0);
    frame(8'h01, 8'h03, 16'h0000, 16'd126, 0, 16'h0000, 0);
    foreach (fn[i]) frame(8'h01, fn[i], 16'h0000, 16'h0001, 0, 16'h0000, 0);
    frame(8'h02, 8'h03, 16'h0000, 16'h0001, 0, 16'h0000, 0);
    frame(8'h01, 8'h03, 16'h0004, 16'h0002, 0, 16'h0000, 1);
    summarize();
  end
endmodule : tb_top

/* File: rtl/mbs_fifo.sv */
// byte fifo with registered head, valid and ready on both sides
module mbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign inReady = (count_reg < (PW+1)'(DEPTH));
  assign push = inValid && inReady;
  assign pop = (!outValid || outReady) && (count_reg != '0);

  function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptrInc

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= ptrInc(wrPtr_reg);
      end
      if (pop) begin
        rdPtr_reg <= ptrInc(rdPtr_reg);
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr_reg];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule : mbs_fifo

/* File: rtl/mbs_pkg.sv */
// shared constants, state type and crc function of the rtu slave responder
package mbs_pkg;

  // ----------------------------------------
  // function and exception codes
  // ----------------------------------------
  localparam logic [7:0] FUNC_READ = 8'h03;
  localparam logic [7:0] FUNC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] ERR_FUNC = 8'h81;
  localparam logic [7:0] ERR_ADDR = 8'h82;
  localparam logic [7:0] ERR_VALUE = 8'h83;

  // ----------------------------------------
  // crc
  // ----------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam int CRC_STEPS = 8;

  // ----------------------------------------
  // frame layout (byte indices and lengths)
  // ----------------------------------------
  localparam logic [8:0] IDX_ADDR = 9'h000;
  localparam logic [8:0] IDX_FUNC = 9'h001;
  localparam logic [8:0] IDX_START_HI = 9'h002;
  localparam logic [8:0] IDX_START_LO = 9'h003;
  localparam logic [8:0] IDX_QTY_HI = 9'h004;
  localparam logic [8:0] IDX_QTY_LO = 9'h005;
  localparam logic [8:0] IDX_BYTES = 9'h006;
  localparam logic [8:0] IDX_DATA = 9'h007;
  localparam logic [8:0] MIN_FRAME_LEN = 9'h004;
  localparam logic [8:0] READ_FRAME_LEN = 9'h008;
  localparam logic [8:0] WRITE_FIXED_LEN = 9'h009;
  localparam logic [8:0] MAX_FRAME_LEN = 9'h100;
  localparam logic [2:0] HDR_LEN_EXC = 3'h3;
  localparam logic [2:0] HDR_LEN_READ = 3'h3;
  localparam logic [2:0] HDR_LEN_WRITE = 3'h6;
  localparam int MAX_RD_REGS = 125;
  localparam int MAX_WR_REGS = 123;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ = 20_000_000;
  localparam longint BAUD_DEFAULT = 9600;
  localparam longint CHAR_BITS = 11;
  localparam longint GAP_TENTH_CHARS = 35;
  localparam longint GAP_NUM = CLK_HZ * CHAR_BITS * GAP_TENTH_CHARS;
  localparam longint GAP_DEN = BAUD_DEFAULT * 10;
  localparam int GAP_CYCLES = int'((GAP_NUM + GAP_DEN - 1) / GAP_DEN);

  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RECV = 4'h1,
    ST_CHECK = 4'h3,
    ST_VCHK = 4'h2,
    ST_WRITE = 4'h6,
    ST_HDR = 4'h7,
    ST_RDA = 4'h5,
    ST_RDH = 4'h4,
    ST_RDL = 4'hc,
    ST_CRCL = 4'hd,
    ST_CRCH = 4'hf
  } mbs_state_t;

  // one byte folded into the accumulator, eight shift steps
  function automatic logic [15:0] crcByte(input logic [15:0] crcIn, input logic [7:0] data);
    logic [15:0] acc;
    acc = crcIn ^ {8'h00, data};
    for (int i = 0; i < CRC_STEPS; i++) begin
      if (acc[0]) begin
        acc = (acc >> 1) ^ CRC_POLY;
      end else begin
        acc = acc >> 1;
      end
    end
    return acc;
  endfunction : crcByte

endpackage : mbs_pkg

/* File: rtl/mbs_rtu_slave.sv */
// rtu slave frame handler: crc check, read/write decode, response build

// Functional notes
// - crc accumulator starts at all ones
// - each byte xored into accumulator low byte
// - shift right, zero in, test bit out
// - xor polynomial when shifted-out bit is one
// - exactly eight steps per byte
// - crc covers frame without check field
// - read reply: addr, 03, bytes, data, crc
// - write reply echoes start and quantity, new crc
// - words and fields sent high byte first
// - exception: addr, func|80, code, crc
// - unsupported function gives code 81
// - address outside range gives code 82
// - illegal written value gives code 83
// - check field sent low byte first
// - answer only own address, else silent
// - characters 8 data bits, framing outside
module mbs_rtu_slave #(
  parameter int GAP_CYCLES = mbs_pkg::GAP_CYCLES,
  parameter int MAX_RD_REGS = mbs_pkg::MAX_RD_REGS,
  parameter int MAX_WR_REGS = mbs_pkg::MAX_WR_REGS,
  parameter logic [15:0] RD_FIRST = 16'h0000,
  parameter logic [15:0] RD_LAST = 16'h00ff,
  parameter logic [15:0] WR_FIRST = 16'h0000,
  parameter logic [15:0] WR_LAST = 16'h00ff,
  parameter int FIFO_DEPTH = mbs_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] slaveAddr,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  output logic [15:0] regRdAddr,
  input wire logic [15:0] regRdData,
  output logic [15:0] regChkAddr,
  output logic [15:0] regChkData,
  input wire logic regValueOk,
  output logic regWrEn,
  output logic [15:0] regWrAddr,
  output logic [15:0] regWrData
);

  // ----------------------------------------
  // state and frame fields
  // ----------------------------------------
  mbs_pkg::mbs_state_t state_reg;
  logic [8:0] len_reg;
  logic [31:0] gapCnt_reg;
  logic [7:0] addr_reg;
  logic [7:0] func_reg;
  logic [15:0] start_reg;
  logic [15:0] qty_reg;
  logic [7:0] byteCnt_reg;
  logic [7:0] bytePrev_reg;
  logic [7:0] byteLast_reg;
  logic [15:0] crcRx_reg;
  logic [15:0] crcHist1_reg;
  logic [15:0] crcHist2_reg;
  logic [15:0] crcTx_reg;
  logic [15:0] words [MAX_WR_REGS];
  logic [15:0] wordIdx_reg;
  logic phase_reg;
  logic [2:0] hdrIdx_reg;
  logic [2:0] hdrLen_reg;
  logic isExc_reg;
  logic [7:0] errCode_reg;
  logic [7:0] loByte_reg;

  logic rxTake;
  logic [8:0] dataOff;
  logic [15:0] wordSel;
  logic emitValid;
  logic [7:0] emitByte;
  logic fifoInReady;
  logic pushed;
  logic lastWord;
  logic crcOk;
  logic [15:0] qty2;

  function automatic logic inRange(input logic [15:0] first, input logic [15:0] cnt,
                                   input logic [15:0] lo, input logic [15:0] hi);
    logic [16:0] last;
    last = {1'b0, first} + {1'b0, cnt} - 17'h00001;
    return (first >= lo) && (last <= {1'b0, hi});
  endfunction : inRange

  assign rxTake = rxValid && rxReady;
  assign dataOff = len_reg - mbs_pkg::IDX_DATA;
  assign wordSel = 16'(dataOff[8:1]);
  assign lastWord = (wordIdx_reg + 16'h0001) == qty_reg;
  assign crcOk = crcHist2_reg == {byteLast_reg, bytePrev_reg};
  assign qty2 = {qty_reg[14:0], 1'b0};
  assign pushed = emitValid && fifoInReady;

  // ----------------------------------------
  // receive: field capture and crc
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      len_reg <= '0;
      addr_reg <= '0;
      func_reg <= '0;
      start_reg <= '0;
      qty_reg <= '0;
      byteCnt_reg <= '0;
      bytePrev_reg <= '0;
      byteLast_reg <= '0;
      crcRx_reg <= mbs_pkg::CRC_INIT;
      crcHist1_reg <= mbs_pkg::CRC_INIT;
      crcHist2_reg <= mbs_pkg::CRC_INIT;
    end else if (state_reg == mbs_pkg::ST_IDLE) begin
      len_reg <= '0;
      crcRx_reg <= mbs_pkg::CRC_INIT;
      crcHist1_reg <= mbs_pkg::CRC_INIT;
      crcHist2_reg <= mbs_pkg::CRC_INIT;
      if (rxTake) begin
        len_reg <= 9'h001;
        addr_reg <= rxData;
        byteLast_reg <= rxData;
        crcRx_reg <= mbs_pkg::crcByte(mbs_pkg::CRC_INIT, rxData);
      end
    end else if (rxTake) begin
      if (len_reg != mbs_pkg::MAX_FRAME_LEN) begin
        len_reg <= len_reg + 9'h001;
      end
      bytePrev_reg <= byteLast_reg;
      byteLast_reg <= rxData;
      crcHist1_reg <= crcRx_reg;
      crcHist2_reg <= crcHist1_reg;
      crcRx_reg <= mbs_pkg::crcByte(crcRx_reg, rxData);
      case (len_reg)
        mbs_pkg::IDX_FUNC: func_reg <= rxData;
        mbs_pkg::IDX_START_HI: start_reg[15:8] <= rxData;
        mbs_pkg::IDX_START_LO: start_reg[7:0] <= rxData;
        mbs_pkg::IDX_QTY_HI: qty_reg[15:8] <= rxData;
        mbs_pkg::IDX_QTY_LO: qty_reg[7:0] <= rxData;
        mbs_pkg::IDX_BYTES: byteCnt_reg <= rxData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (state_reg == mbs_pkg::ST_RECV && rxTake && len_reg >= mbs_pkg::IDX_DATA
        && wordSel < 16'(MAX_WR_REGS)) begin
      if (!dataOff[0]) begin
        words[wordSel[$clog2(MAX_WR_REGS)-1:0]][15:8] <= rxData;
      end else begin
        words[wordSel[$clog2(MAX_WR_REGS)-1:0]][7:0] <= rxData;
      end
    end
  end

  // ----------------------------------------
  // idle gap timer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt_reg <= '0;
    end else if (state_reg != mbs_pkg::ST_RECV || rxTake) begin
      gapCnt_reg <= '0;
    end else begin
      gapCnt_reg <= gapCnt_reg + 32'h00000001;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= mbs_pkg::ST_IDLE;
      wordIdx_reg <= '0;
      phase_reg <= 1'b0;
      hdrIdx_reg <= '0;
      hdrLen_reg <= '0;
      isExc_reg <= 1'b0;
      errCode_reg <= '0;
    end else begin
      case (state_reg)
        mbs_pkg::ST_IDLE: begin
          if (rxTake) begin
            state_reg <= mbs_pkg::ST_RECV;
          end
        end
        mbs_pkg::ST_RECV: begin
          if (!rxTake && gapCnt_reg >= 32'(GAP_CYCLES - 1)) begin
            state_reg <= mbs_pkg::ST_CHECK;
          end
        end
        mbs_pkg::ST_CHECK: begin
          wordIdx_reg <= '0;
          phase_reg <= 1'b0;
          hdrIdx_reg <= '0;
          isExc_reg <= 1'b1;
          hdrLen_reg <= mbs_pkg::HDR_LEN_EXC;
          state_reg <= mbs_pkg::ST_HDR;
          if (len_reg < mbs_pkg::MIN_FRAME_LEN || len_reg == mbs_pkg::MAX_FRAME_LEN
              || !crcOk) begin
            state_reg <= mbs_pkg::ST_IDLE;
          end else if (addr_reg != slaveAddr) begin
            state_reg <= mbs_pkg::ST_IDLE;
          end else if (func_reg == mbs_pkg::FUNC_READ) begin
            if (len_reg != mbs_pkg::READ_FRAME_LEN) begin
              state_reg <= mbs_pkg::ST_IDLE;
            end else if (qty_reg == '0 || qty_reg > 16'(MAX_RD_REGS)) begin
              errCode_reg <= mbs_pkg::ERR_VALUE;
            end else if (!inRange(start_reg, qty_reg, RD_FIRST, RD_LAST)) begin
              errCode_reg <= mbs_pkg::ERR_ADDR;
            end else begin
              isExc_reg <= 1'b0;
              hdrLen_reg <= mbs_pkg::HDR_LEN_READ;
            end
          end else if (func_reg == mbs_pkg::FUNC_WRITE) begin
            if (qty_reg == '0 || qty_reg > 16'(MAX_WR_REGS)
                || {8'h00, byteCnt_reg} != qty2) begin
              errCode_reg <= mbs_pkg::ERR_VALUE;
            end else if (len_reg != mbs_pkg::WRITE_FIXED_LEN + qty2[8:0]) begin
              state_reg <= mbs_pkg::ST_IDLE;
            end else if (!inRange(start_reg, qty_reg, WR_FIRST, WR_LAST)) begin
              errCode_reg <= mbs_pkg::ERR_ADDR;
            end else begin
              isExc_reg <= 1'b0;
              hdrLen_reg <= mbs_pkg::HDR_LEN_WRITE;
              state_reg <= mbs_pkg::ST_VCHK;
            end
          end else begin
            errCode_reg <= mbs_pkg::ERR_FUNC;
          end
        end
        mbs_pkg::ST_VCHK: begin
          phase_reg <= !phase_reg;
          if (phase_reg) begin
            if (!regValueOk) begin
              isExc_reg <= 1'b1;
              hdrLen_reg <= mbs_pkg::HDR_LEN_EXC;
              errCode_reg <= mbs_pkg::ERR_VALUE;
              state_reg <= mbs_pkg::ST_HDR;
            end else if (lastWord) begin
              wordIdx_reg <= '0;
              state_reg <= mbs_pkg::ST_WRITE;
            end else begin
              wordIdx_reg <= wordIdx_reg + 16'h0001;
            end
          end
        end
        mbs_pkg::ST_WRITE: begin
          wordIdx_reg <= wordIdx_reg + 16'h0001;
          if (lastWord) begin
            wordIdx_reg <= '0;
            state_reg <= mbs_pkg::ST_HDR;
          end
        end
        mbs_pkg::ST_HDR: begin
          if (pushed) begin
            hdrIdx_reg <= hdrIdx_reg + 3'h1;
            if (hdrIdx_reg == hdrLen_reg - 3'h1) begin
              if (!isExc_reg && func_reg == mbs_pkg::FUNC_READ) begin
                state_reg <= mbs_pkg::ST_RDA;
              end else begin
                state_reg <= mbs_pkg::ST_CRCL;
              end
            end
          end
        end
        mbs_pkg::ST_RDA: state_reg <= mbs_pkg::ST_RDH;
        mbs_pkg::ST_RDH: begin
          if (pushed) begin
            state_reg <= mbs_pkg::ST_RDL;
          end
        end
        mbs_pkg::ST_RDL: begin
          if (pushed) begin
            wordIdx_reg <= wordIdx_reg + 16'h0001;
            state_reg <= lastWord ? mbs_pkg::ST_CRCL : mbs_pkg::ST_RDA;
          end
        end
        mbs_pkg::ST_CRCL: begin
          if (pushed) begin
            state_reg <= mbs_pkg::ST_CRCH;
          end
        end
        mbs_pkg::ST_CRCH: begin
          if (pushed) begin
            state_reg <= mbs_pkg::ST_IDLE;
          end
        end
        default: state_reg <= mbs_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive handshake
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxReady <= 1'b0;
    end else begin
      rxReady <= (state_reg == mbs_pkg::ST_IDLE || state_reg == mbs_pkg::ST_RECV)
                 && !(state_reg == mbs_pkg::ST_RECV && !rxTake
                      && gapCnt_reg >= 32'(GAP_CYCLES - 1));
    end
  end

  // ----------------------------------------
  // meter register access
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdAddr <= '0;
      regChkAddr <= '0;
      regChkData <= '0;
      regWrEn <= 1'b0;
      regWrAddr <= '0;
      regWrData <= '0;
      loByte_reg <= '0;
    end else begin
      regWrEn <= 1'b0;
      if (state_reg == mbs_pkg::ST_RDA) begin
        regRdAddr <= start_reg + wordIdx_reg;
      end
      if (state_reg == mbs_pkg::ST_RDH && pushed) begin
        loByte_reg <= regRdData[7:0];
      end
      if (state_reg == mbs_pkg::ST_VCHK && !phase_reg) begin
        regChkAddr <= start_reg + wordIdx_reg;
        regChkData <= words[wordIdx_reg[$clog2(MAX_WR_REGS)-1:0]];
      end
      if (state_reg == mbs_pkg::ST_WRITE) begin
        regWrEn <= 1'b1;
        regWrAddr <= start_reg + wordIdx_reg;
        regWrData <= words[wordIdx_reg[$clog2(MAX_WR_REGS)-1:0]];
      end
    end
  end

  // ----------------------------------------
  // response byte source and crc
  // ----------------------------------------
  always_comb begin
    emitValid = 1'b0;
    emitByte = 8'h00;
    case (state_reg)
      mbs_pkg::ST_HDR: begin
        emitValid = 1'b1;
        case (hdrIdx_reg)
          3'h0: emitByte = slaveAddr;
          3'h1: emitByte = isExc_reg ? (func_reg | mbs_pkg::EXC_FLAG) : func_reg;
          3'h2: begin
            if (isExc_reg) begin
              emitByte = errCode_reg;
            end else if (func_reg == mbs_pkg::FUNC_READ) begin
              emitByte = qty2[7:0];
            end else begin
              emitByte = start_reg[15:8];
            end
          end
          3'h3: emitByte = start_reg[7:0];
          3'h4: emitByte = qty_reg[15:8];
          3'h5: emitByte = qty_reg[7:0];
          default: emitByte = 8'h00;
        endcase
      end
      mbs_pkg::ST_RDH: begin
        emitValid = 1'b1;
        emitByte = regRdData[15:8];
      end
      mbs_pkg::ST_RDL: begin
        emitValid = 1'b1;
        emitByte = loByte_reg;
      end
      mbs_pkg::ST_CRCL: begin
        emitValid = 1'b1;
        emitByte = crcTx_reg[7:0];
      end
      mbs_pkg::ST_CRCH: begin
        emitValid = 1'b1;
        emitByte = crcTx_reg[15:8];
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crcTx_reg <= mbs_pkg::CRC_INIT;
    end else if (state_reg == mbs_pkg::ST_CHECK) begin
      crcTx_reg <= mbs_pkg::CRC_INIT;
    end else if (pushed && state_reg != mbs_pkg::ST_CRCL && state_reg != mbs_pkg::ST_CRCH) begin
      crcTx_reg <= mbs_pkg::crcByte(crcTx_reg, emitByte);
    end
  end

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  mbs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_txFifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(emitValid),
    .inData(emitByte),
    .inReady(fifoInReady),
    .outValid(txValid),
    .outData(txData),
    .outReady(txReady)
  );

endmodule : mbs_rtu_slave
